/* File: src/rtce_slave.sv */
// serial slave front end: address decode, pointer, read and write flow
`timescale 1ns/1ps
// How it works
// [RULE1] Answer only to top nibble 1101 with block 000, 001 or 010.
// [RULE2] Last address bit picks direction: one reads, zero writes.
// [RULE3] Write address to eeprom while programming gets a not-acknowledge.
// [RULE4] Programming starts on the stop that ends a write, never earlier.
// [RULE5] Polling with write addresses gets an ack once programming ends.
// [RULE6] Clock block stays readable and writable during programming.
// [RULE7] Pointer holds last accessed address plus one; plain reads use it. An eeprom write at a page end sends the pointer back to the page start.
// [RULE8] Read address is acked, then eight bits go out MSB first.
// [RULE9] Master not-acknowledge ends the read; the data line is released.
// [RULE10] Pointer loads from the word address before a repeated start.
// [RULE11] Master acknowledge moves the pointer on and sends the next byte.
// [RULE12] Reads cross pages freely; low byte wraps inside the same block.
// [RULE13] Block select bits form the top of the word address.
// [RULE14] First byte after a write address is the word address.
// [RULE15] Bad code or block leaves the line free for the whole transfer.
module rtce_slave
    import rtce_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROG_CYCLES_DFLT
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    output logic      prog_busy
);

    logic              scl_s1, scl_s2, scl_s3;
    logic              sda_s1, sda_s2, sda_s3;
    logic              scl_rise, scl_fall, start_det, stop_det;
    rtce_state_e       state;
    logic [3:0]        bit_cnt;
    logic [7:0]        shreg;
    logic [7:0]        txreg;
    logic              master_ack;
    logic              eep_dirty;
    logic [ADDR_W-1:0] ptr;
    logic [7:0]        rd_data;
    logic              wr_en;
    logic [7:0]        wr_data;
    logic              commit;
    logic              byte_done;
    logic              addr_match;
    logic              addr_busy;
    logic              ack_phase;

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers; third stage only feeds edge detection
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
        end
    end

    // bus events; data changes while clock is high are start and stop
    assign scl_rise  = scl_s2 && !scl_s3;
    assign scl_fall  = !scl_s2 && scl_s3;
    assign start_det = scl_s2 && scl_s3 && !sda_s2 && sda_s3;
    assign stop_det  = scl_s2 && scl_s3 && sda_s2 && !sda_s3;
    assign byte_done = scl_fall && (bit_cnt == BITS_DONE);

    // address byte decode; any eeprom access is refused while programming
    assign addr_match = (shreg[CODE_MSB:CODE_LSB] == CTRL_CODE)     // RULE1
                     && rtce_blk_ok(shreg[BLK_MSB:BLK_LSB]);        // RULE15
    assign addr_busy  = prog_busy && rtce_is_eep(shreg[BLK_MSB:BLK_LSB]);

    // ninth clock of a byte; the received byte must survive it
    assign ack_phase  = state inside {ST_ADDR_ACK, ST_WORD_ACK,
                                      ST_WDAT_ACK, ST_RACK};

    ////////////////////////////////////////////////////////////////////////
    // received bits shift in on the rising clock edge, MSB first
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shreg      <= 8'h00;
            master_ack <= 1'b0;
        end else if (scl_rise) begin
            master_ack <= !sda_s2;
            if (!ack_phase) begin
                // the ack bit would push the direction bit out otherwise
                shreg <= {shreg[6:0], sda_s2};
            end
        end
    end

    // bit counter, cleared whenever a new byte phase opens
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bit_cnt <= 4'h0;
        end else if (start_det || stop_det) begin
            bit_cnt <= 4'h0;
        end else if (scl_fall && bit_cnt == BITS_DONE) begin
            bit_cnt <= 4'h0;
        end else if (scl_fall && ack_phase) begin
            bit_cnt <= 4'h0;
        end else if (scl_rise && bit_cnt != BITS_DONE) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protocol sequencer; line changes happen on the falling clock, except the release at a start or stop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
        end else if (start_det) begin
            state <= ST_ADDR;            // repeated start ends a write; its buffered bytes still commit at the stop
        end else if (stop_det) begin
            state <= ST_IDLE;
        end else if (scl_fall) begin
            unique case (state)
                ST_IDLE, ST_IGNORE: begin
                    state <= state;
                end
                ST_ADDR: begin
                    if (bit_cnt == BITS_DONE) begin
                        if (addr_match && !addr_busy) begin // RULE3 RULE5 RULE6
                            state <= ST_ADDR_ACK;
                        end else begin
                            state <= ST_IGNORE;       // RULE15
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    state <= (shreg[RW_BIT] == RW_READ) ? ST_RDATA
                                                        : ST_WORD; // RULE2
                end
                ST_WORD: begin
                    if (bit_cnt == BITS_DONE) state <= ST_WORD_ACK;
                end
                ST_WORD_ACK, ST_WDAT_ACK: begin
                    state <= ST_WDATA;
                end
                ST_WDATA: begin
                    if (bit_cnt == BITS_DONE) state <= ST_WDAT_ACK;
                end
                ST_RDATA: begin
                    if (bit_cnt == BITS_DONE) state <= ST_RACK;
                end
                ST_RACK: begin
                    state <= master_ack ? ST_RDATA : ST_IGNORE; // RULE9 RULE11
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit shifter and open-drain drive: pull low for ack or a zero bit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            txreg   <= 8'h00;
            sda_oe  <= 1'b0;
            sda_out <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_oe  <= 1'b0;
        end else if (scl_fall) begin
            sda_out <= 1'b0;
            unique case (state)
                ST_ADDR: begin
                    sda_oe <= byte_done && addr_match && !addr_busy; // RULE3
                end
                ST_WORD, ST_WDATA: begin
                    sda_oe <= byte_done;
                end
                ST_ADDR_ACK: begin
                    if (shreg[RW_BIT] == RW_READ) begin
                        txreg  <= rd_data;                       // RULE7
                        sda_oe <= !rd_data[7];                   // RULE8
                    end else begin
                        sda_oe <= 1'b0;
                    end
                end
                ST_RDATA: begin
                    if (bit_cnt == BITS_DONE) begin
                        sda_oe <= 1'b0;        // master owns the ack bit
                    end else begin
                        txreg  <= {txreg[6:0], 1'b0};
                        sda_oe <= !txreg[6];                     // RULE8
                    end
                end
                ST_RACK: begin
                    if (master_ack) begin
                        txreg  <= rd_data;                       // RULE11
                        sda_oe <= !rd_data[7];
                    end else begin
                        sda_oe <= 1'b0;                          // RULE9
                    end
                end
                ST_IDLE, ST_IGNORE, ST_WORD_ACK, ST_WDAT_ACK: begin
                    sda_oe <= 1'b0;                              // RULE15
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address pointer: block bits on top, byte below, wraps inside block
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ptr <= PTR_RESET;
        end else if (scl_fall) begin
            if (state == ST_ADDR && byte_done && addr_match && !addr_busy) begin
                ptr[10:8] <= shreg[BLK_MSB:BLK_LSB];             // RULE13
            end else if (state == ST_WORD && byte_done) begin
                ptr[7:0] <= shreg;                               // RULE10 RULE14
            end else if (state == ST_WDATA && byte_done) begin
                // eeprom page writes roll over inside the eight-byte page
                if (rtce_is_eep(ptr[10:8])) begin
                    ptr[2:0] <= ptr[2:0] + 3'h1;
                end else begin
                    ptr[7:0] <= ptr[7:0] + 8'h01;
                end
            end else if (state == ST_RDATA && byte_done) begin
                ptr[7:0] <= ptr[7:0] + 8'h01;                    // RULE7 RULE12
            end
        end
    end

    // write strobe to storage, and a dirty mark for the eeprom page
    assign wr_en   = scl_fall && state == ST_WDATA && bit_cnt == BITS_DONE;
    assign wr_data = shreg;
    assign commit  = stop_det && eep_dirty;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            eep_dirty <= 1'b0;
        end else if (commit) begin
            eep_dirty <= 1'b0;                                   // RULE4
        end else if (wr_en && rtce_is_eep(ptr[10:8])) begin
            eep_dirty <= 1'b1;
        end
    end

    rtce_mem #(
        .PROG_CYCLES (PROG_CYCLES)
    ) u_mem (
        .clk       (clk),
        .resetn    (resetn),
        .rd_addr   (ptr),
        .rd_data   (rd_data),
        .wr_en     (wr_en),
        .wr_addr   (ptr),
        .wr_data   (wr_data),
        .commit    (commit),
        .prog_busy (prog_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_code_match: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_ADDR_ACK && $past(state) == ST_ADDR)
        |-> $past(shreg[7:4]) == CTRL_CODE && ptr[10:8] == $past(shreg[3:1]))
        else $error("address acknowledged with wrong code"); // RULE1

    chk_dir_select: assert property (@(posedge clk) disable iff (!resetn)
        (scl_fall && state == ST_ADDR_ACK && !start_det && !stop_det)
        |=> state == (shreg[0] ? ST_RDATA : ST_WORD))
        else $error("direction bit not honoured"); // RULE2

    chk_busy_nack: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_ADDR && byte_done && prog_busy && !start_det
         && !stop_det && rtce_is_eep(shreg[3:1]))
        |=> state == ST_IGNORE && !sda_oe)
        else $error("eeprom address acknowledged while programming"); // RULE3

    chk_prog_stop: assert property (@(posedge clk) disable iff (!resetn)
        $rose(prog_busy) |-> $past(stop_det) && $past(eep_dirty))
        else $error("programming started without a stop"); // RULE4

    chk_clock_open: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_ADDR && byte_done && !start_det && !stop_det
         && shreg[7:1] == {CTRL_CODE, BLK_CLOCK})
        |=> state == ST_ADDR_ACK ##0 sda_oe)
        else $error("clock block refused"); // RULE6

    chk_msb_first: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_RDATA && $past(state) == ST_ADDR_ACK)
        |-> sda_oe == !$past(rd_data[7]) && txreg == $past(rd_data))
        else $error("first data bit is not the msb"); // RULE8

    chk_nack_free: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_RACK && scl_fall && !master_ack)
        |=> !sda_oe [*3])
        else $error("line held after master nack"); // RULE9

    chk_ptr_wrap: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_RDATA && byte_done && !start_det && !stop_det)
        |=> ptr == {$past(ptr[10:8]), $past(ptr[7:0]) + 8'h01})
        else $error("read pointer did not step inside block"); // RULE12

    chk_word_load: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_WORD && byte_done && !start_det && !stop_det)
        |=> ptr[7:0] == $past(shreg) && state == ST_WORD_ACK)
        else $error("word address not loaded"); // RULE14

    chk_ignore_quiet: assert property (@(posedge clk) disable iff (!resetn)
        (state == ST_IGNORE && $past(state) == ST_IGNORE) |-> !sda_oe)
        else $error("line driven during ignored transfer"); // RULE15

endmodule : rtce_slave

/* File: src/rtce_pkg.sv */
// shared constants, state codes and address decode helpers for the serial slave
package rtce_pkg;

    // slave address byte layout
    localparam logic [3:0] CTRL_CODE   = 4'hd;   // fixed control code 1101
    localparam int         CODE_MSB    = 7;
    localparam int         CODE_LSB    = 4;
    localparam int         BLK_MSB     = 3;
    localparam int         BLK_LSB     = 1;
    localparam int         RW_BIT      = 0;
    localparam logic       RW_READ     = 1'b1;
    localparam logic       RW_WRITE    = 1'b0;

    // block select codes
    localparam logic [2:0] BLK_CLOCK   = 3'h0;
    localparam logic [2:0] BLK_EEP_LO  = 3'h1;
    localparam logic [2:0] BLK_EEP_HI  = 3'h2;

    // internal word address: three block bits above one byte
    localparam int         ADDR_W      = 11;
    localparam int         CLK_BYTES   = 16;
    localparam int         CLK_IDX_W   = 4;
    localparam int         EEP_BYTES   = 512;
    localparam int         EEP_IDX_W   = 9;
    localparam int         PAGE_BYTES  = 8;
    localparam int         PAGE_IDX_W  = 3;
    localparam logic [7:0] EEP_RESET   = 8'hff;  // erased cell value
    localparam logic [7:0] CLK_RESET   = 8'h00;
    localparam logic [ADDR_W-1:0] PTR_RESET = 11'h000;

    // bit counter and self-timed programming
    localparam logic [3:0] BITS_DONE     = 4'h8;
    localparam int         CLK_PERIOD_NS = 8;
    localparam int         PROG_TIME_NS  = 5000000;
    localparam int         PROG_CYCLES_DFLT = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int         PROG_CNT_W    = 20;

    // protocol states
    typedef enum logic [3:0] {
        ST_IDLE     = 4'b0000,
        ST_ADDR     = 4'b0001,
        ST_ADDR_ACK = 4'b0010,
        ST_WORD     = 4'b0011,
        ST_WORD_ACK = 4'b0100,
        ST_WDATA    = 4'b0101,
        ST_WDAT_ACK = 4'b0110,
        ST_RDATA    = 4'b0111,
        ST_RACK     = 4'b1000,
        ST_IGNORE   = 4'b1001
    } rtce_state_e;

    // block is one of the eeprom halves
    function automatic logic rtce_is_eep(input logic [2:0] blk);
        return (blk == BLK_EEP_LO) || (blk == BLK_EEP_HI);
    endfunction : rtce_is_eep

    // block select names one of the three supported blocks
    function automatic logic rtce_blk_ok(input logic [2:0] blk);
        logic block_select_high;
        block_select_high = blk[2];
        return !block_select_high && (blk != 3'h3);
    endfunction : rtce_blk_ok

    // eeprom cell index: mid select bit picks the upper half
    function automatic logic [EEP_IDX_W-1:0] rtce_eep_idx(
        input logic [ADDR_W-1:0] a);
        logic block_select_mid;
        block_select_mid = a[9];
        return {block_select_mid, a[7:0]};
    endfunction : rtce_eep_idx

endpackage : rtce_pkg

/* File: src/rtce_mem.sv */
// storage for clock bytes and eeprom, page buffer and programming timer
`timescale 1ns/1ps
module rtce_mem
    import rtce_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROG_CYCLES_DFLT
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [7:0]        rd_data,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [7:0]        wr_data,
    input  wire logic              commit,
    output logic                   prog_busy
);

    logic [7:0]                 clk_mem  [CLK_BYTES];
    logic [7:0]                 eep_mem  [EEP_BYTES];
    logic [7:0]                 page_buf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0]      page_vld;
    logic [EEP_IDX_W-1:PAGE_IDX_W] page_base;
    logic [PROG_CNT_W-1:0]      prog_cnt;
    logic [EEP_IDX_W-1:0]       wr_idx;

    ////////////////////////////////////////////////////////////////////////
    // read path: clock block aliases above its size
    always_comb begin
        if (rd_addr[10:8] == BLK_CLOCK) begin
            rd_data = clk_mem[rd_addr[CLK_IDX_W-1:0]];
        end else begin
            rd_data = eep_mem[rtce_eep_idx(rd_addr)];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock bytes take writes at once, even while eeprom programs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < CLK_BYTES; i++) clk_mem[i] <= CLK_RESET;
        end else if (wr_en && wr_addr[10:8] == BLK_CLOCK) begin
            clk_mem[wr_addr[CLK_IDX_W-1:0]] <= wr_data;  // RULE6
        end
    end

    // eeprom cell index of the write pointer; its upper bits name the page
    assign wr_idx = rtce_eep_idx(wr_addr);

    // eeprom bytes wait in the page buffer until the stop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < PAGE_BYTES; i++) page_buf[i] <= CLK_RESET;
            page_vld  <= '0;
            page_base <= '0;
        end else if (commit) begin
            page_vld <= '0;
        end else if (wr_en && rtce_is_eep(wr_addr[10:8])) begin
            page_buf[wr_addr[PAGE_IDX_W-1:0]] <= wr_data;
            page_vld[wr_addr[PAGE_IDX_W-1:0]] <= 1'b1;
            page_base <= wr_idx[EEP_IDX_W-1:PAGE_IDX_W];
        end
    end

    // commit copies only the touched bytes; the rest of the page stays
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < EEP_BYTES; i++) eep_mem[i] <= EEP_RESET;
        end else if (commit) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (page_vld[i]) begin
                    eep_mem[{page_base, PAGE_IDX_W'(i)}] <= page_buf[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // self-timed programming window starts on the commit pulse
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prog_busy <= 1'b0;
            prog_cnt  <= '0;
        end else if (commit) begin
            prog_busy <= 1'b1;                                // RULE4
            prog_cnt  <= '0;
        end else if (prog_busy) begin
            if (prog_cnt == PROG_CNT_W'(PROG_CYCLES - 1)) begin
                prog_busy <= 1'b0;
            end
            prog_cnt <= prog_cnt + PROG_CNT_W'(1);
        end
    end

    chk_prog_cause: assert property (@(posedge clk) disable iff (!resetn)
        $rose(prog_busy) |-> $past(commit)) // RULE4
        else $error("programming began without a commit");

endmodule : rtce_mem

/* File: tb/rtce_master_model.sv */
// bus master model: drives the clock line and pulls the data line low
`timescale 1ns/1ps
module rtce_master_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    // quarter of the 160 ns bus clock period, in system clocks
    localparam int QTR = 5;
    // idle bus at time zero: both lines released
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    // start (data falls) or stop (data rises) while the clock is high
    task automatic frame(input logic is_start);
        sda_low = !is_start;
        repeat (QTR) @(negedge clk);
        scl = 1'b1;
        repeat (QTR) @(negedge clk);
        sda_low = is_start;
        repeat (QTR) @(negedge clk);
        scl = !is_start;
        repeat (QTR) @(negedge clk);
    endtask : frame
    // nine pulses, MSB first; a one leaves the line free for the slave,
    // which is read mid-high so its answer has long settled
    task automatic xfer(input logic [8:0] d, output logic [8:0] seen);
        for (int i = 8; i >= 0; i--) begin
            sda_low = !d[i];
            repeat (QTR) @(negedge clk);
            scl = 1'b1;
            repeat (QTR) @(negedge clk);
            seen[i] = sda;
            repeat (QTR) @(negedge clk);
            scl = 1'b0;
            repeat (QTR) @(negedge clk);
        end
    endtask : xfer
endmodule : rtce_master_model

/* File: tb/tb.sv */
// top bench: serial slave under a bus master model, self-checking
`timescale 1ns/1ps
module tb;
    import rtce_pkg::*;
    logic       clk, resetn, scl, sda_low, sda_out, sda_oe, prog_busy, sda;
    logic [8:0] q;
    int         err_count = 0, total_checks = 0;
    // open-drain data wire with pull-up: low if either party pulls
    assign sda = !sda_low && !(sda_oe && !sda_out);
    // programming shortened to 2000 clocks, still longer than busy checks
    rtce_slave #(.PROG_CYCLES(2000)) u_rtce_slave (
        .clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .prog_busy(prog_busy));
    rtce_master_model u_rtce_master_model (
        .clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    // 125 MHz system clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////
    // compare and count; a mismatch is printed at once
    task automatic check(input string name, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // the single exit of the run
    task automatic give_verdict();
        if (err_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // bus helpers: frame conditions, byte out with ack, byte in
    task automatic bus(input logic is_start);
        u_rtce_master_model.frame(is_start);
    endtask : bus
    task automatic send(input logic [7:0] b, input logic ack);
        u_rtce_master_model.xfer({b, 1'b1}, q);
        check($sformatf("ack %h", b), 8'(!q[0]), 8'(ack));
    endtask : send
    task automatic rd(input logic ack, input logic [7:0] exp);
        u_rtce_master_model.xfer({8'hff, !ack}, q);
        check("read byte", q[8:1], exp);
    endtask : rd
    // foreign control code and unsupported block: never acknowledged
    task automatic t_refuse();
        bus(1'b1);
        send(8'ha2, 1'b0);
        bus(1'b1);
        send(8'hd6, 1'b0);
        send(8'h00, 1'b0);
    endtask : t_refuse
    // upper eeprom write, polls and clock access while it programs
    task automatic t_write_poll();
        bus(1'b1);
        send(8'hd4, 1'b1);
        send(8'h00, 1'b1);
        send(8'h5a, 1'b1);
        check("busy before stop", 8'(prog_busy), 8'h00);
        bus(1'b0);
        check("busy after stop", 8'(prog_busy), 8'h01);
        bus(1'b1);
        send(8'hd4, 1'b0);
        bus(1'b1);
        send(8'hd0, 1'b1);
        send(8'h03, 1'b1);
        send(8'h3c, 1'b1);
        send(8'hc3, 1'b1);
        bus(1'b1);
        send(8'hd1, 1'b1);
        check("busy at clock read", 8'(prog_busy), 8'h01);
        rd(1'b0, CLK_RESET);
        bus(1'b0);
        for (int n = 0; prog_busy !== 1'b0; n++) begin
            @(negedge clk);
            if (n == 3000) begin
                check("programming end", 8'(prog_busy), 8'h00);
                give_verdict();
            end
        end
        bus(1'b1);
        send(8'hd4, 1'b1);
        send(8'h00, 1'b1);
        bus(1'b1);
        send(8'hd5, 1'b1);
        rd(1'b0, 8'h5a);
        bus(1'b1);
        send(8'hd5, 1'b1);
        rd(1'b0, EEP_RESET);
        bus(1'b0);
    endtask : t_write_poll
    // clock block random read, then wrap at the end of lower eeprom
    task automatic t_read();
        bus(1'b1);
        send(8'hd0, 1'b1);
        send(8'h03, 1'b1);
        bus(1'b1);
        send(8'hd1, 1'b1);
        rd(1'b1, 8'h3c);
        rd(1'b0, 8'hc3);
        check("line released", 8'(sda_oe), 8'h00);
        bus(1'b1);
        send(8'hd2, 1'b1);
        send(8'hff, 1'b1);
        bus(1'b1);
        send(8'hd3, 1'b1);
        rd(1'b1, EEP_RESET);
        rd(1'b0, EEP_RESET);
        bus(1'b0);
    endtask : t_read
    // reset for 20 clocks, then the scenarios in turn
    initial begin
        resetn = 1'b0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        t_refuse();
        t_write_poll();
        t_read();
        give_verdict();
    end
endmodule : tb
